// *** vip_controller.sv ***
// Added by the designer: the plain strobed port and the address map.
module vip_controller
	import vip_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire vip_bus_t bus,
	output logic [31:0] rdata,
	input wire logic [31:0] periph_irq,
	input wire logic [VIP_EXT-1:0] ext_irq_pin,
	output logic irq_out,
	output logic fiq_out,
	output logic event_irq
);

	// Pin synchroniser and agreement filter
	logic [VIP_EXT-1:0] ext_s1, ext_s2, ext_s3, ext_level;
	logic [VIP_EXT-1:0] next_ext_level;

	// Programmable state
	logic [31:0] type_sel, next_type_sel;
	logic [31:0] line_en, next_line_en;
	logic [31:0] soft_req, next_soft_req;
	logic [31:0] def_addr, next_def_addr;
	logic [31:0] slot_addr [VIP_SLOTS];
	logic [31:0] next_slot_addr [VIP_SLOTS];
	vip_slot_ctrl_t slot_ctrl [VIP_SLOTS];
	vip_slot_ctrl_t next_slot_ctrl [VIP_SLOTS];
	logic [VIP_SVC_W-1:0] in_service, next_in_service;
	logic [VIP_EVT_W-1:0] evt_stat, next_evt_stat;
	logic [VIP_EVT_W-1:0] evt_en, next_evt_en;
	logic [31:0] next_rdata;
	logic next_irq_out, next_fiq_out, next_event_irq;

	// Derived combinational values
	logic [31:0] raw_lines, irq_stat, fiq_stat, bound;
	logic [VIP_SLOTS-1:0] slot_hit;
	logic [4:0] win_lvl, act_lvl;
	logic irq_req;
	logic [3:0] slot_idx;
	logic slot_page_ok;
	logic is_cur, is_slot_a, is_slot_c, mapped;

	// Three-stage pin capture
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ext_s1 <= '0;
			ext_s2 <= '0;
			ext_s3 <= '0;
			ext_level <= '0;
		end else begin
			ext_s1 <= ext_irq_pin;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
			ext_level <= next_ext_level;
		end
	end

	// Level changes only once two stages agree
	always_comb begin
		next_ext_level = ext_level;
		for (int i = 0; i < VIP_EXT; i++) begin
			if (ext_s2[i] == ext_s3[i])
				next_ext_level[i] = ext_s3[i];
		end
	end

	// Line assembly with fixed positions
	always_comb begin
		raw_lines = periph_irq;
		raw_lines[VIP_LINE_SPARE] = 1'b0; // Spare line is software only
		for (int i = 0; i < VIP_EXT; i++)
			raw_lines[VIP_LINE_EXT0 + i] = ext_level[i];
		raw_lines = raw_lines | soft_req;
		irq_stat = raw_lines & line_en & ~type_sel;
		fiq_stat = raw_lines & line_en & type_sel;
	end

	// Hardware arbitration
	always_comb begin
		// Slot bindings and pending hits
		bound = '0;
		slot_hit = '0;
		for (int i = 0; i < VIP_SLOTS; i++) begin
			if (slot_ctrl[i].en) begin
				bound[slot_ctrl[i].src] = 1'b1;
				slot_hit[i] = irq_stat[slot_ctrl[i].src];
			end
		end
		// Best pending level
		win_lvl = VIP_LVL_NONE;
		if (|(irq_stat & ~bound))
			win_lvl = VIP_LVL_DEF;
		for (int i = VIP_SLOTS - 1; i >= 0; i--) begin
			if (slot_hit[i])
				win_lvl = 5'(i);
		end
		// Highest level in service
		act_lvl = VIP_LVL_NONE;
		for (int i = VIP_SVC_W - 1; i >= 0; i--) begin
			if (in_service[i])
				act_lvl = 5'(i);
		end
		irq_req = win_lvl < act_lvl;
	end

	// Address decode
	always_comb begin
		slot_idx = bus.addr[VIP_IDX_MSB:VIP_IDX_LSB];
		slot_page_ok = bus.addr[VIP_GAP_MSB:VIP_GAP_LSB] == '0;
		is_cur = bus.addr == VIP_CURRENT_VECTOR;
		is_slot_a = slot_page_ok
			&& bus.addr[VIP_PAGE_MSB:VIP_PAGE_LSB] == VIP_SLOT_ADDR_PAGE;
		is_slot_c = slot_page_ok
			&& bus.addr[VIP_PAGE_MSB:VIP_PAGE_LSB] == VIP_SLOT_CTRL_PAGE;
		// Known register offsets
		case (bus.addr)
			VIP_IRQ_STATUS, VIP_FIQ_STATUS, VIP_RAW_STATUS,
			VIP_TYPE_SELECT, VIP_LINE_ENABLE, VIP_LINE_DISABLE,
			VIP_SOFT_RAISE, VIP_SOFT_CLEAR, VIP_CURRENT_VECTOR,
			VIP_DEFAULT_VECTOR, VIP_EVENT_STATUS, VIP_EVENT_CLEAR,
			VIP_EVENT_ENABLE: mapped = 1'b1;
			default: mapped = is_slot_a || is_slot_c;
		endcase
	end

	// Configuration register writes
	always_comb begin
		next_type_sel = type_sel;
		next_line_en = line_en;
		next_soft_req = soft_req;
		next_def_addr = def_addr;
		next_evt_en = evt_en;
		for (int i = 0; i < VIP_SLOTS; i++) begin
			next_slot_addr[i] = slot_addr[i];
			next_slot_ctrl[i] = slot_ctrl[i];
		end
		if (bus.wr) begin
			case (bus.addr)
				VIP_TYPE_SELECT: next_type_sel = bus.wdata;
				VIP_LINE_ENABLE: next_line_en = line_en | bus.wdata;
				VIP_LINE_DISABLE: next_line_en = line_en & ~bus.wdata;
				VIP_SOFT_RAISE: next_soft_req = soft_req | bus.wdata;
				VIP_SOFT_CLEAR: next_soft_req = soft_req & ~bus.wdata;
				VIP_DEFAULT_VECTOR: next_def_addr = bus.wdata;
				VIP_EVENT_ENABLE: next_evt_en = bus.wdata[VIP_EVT_W-1:0];
				default: begin
					if (is_slot_a)
						next_slot_addr[slot_idx] = bus.wdata;
					if (is_slot_c) begin
						next_slot_ctrl[slot_idx].en =
							bus.wdata[VIP_CTRL_EN_BIT];
						next_slot_ctrl[slot_idx].src =
							bus.wdata[VIP_SRC_W-1:0];
					end
				end
			endcase
		end
	end

	// Configuration registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			type_sel <= '0;
			line_en <= '0;
			soft_req <= '0;
			def_addr <= '0;
			evt_en <= '0;
			for (int i = 0; i < VIP_SLOTS; i++) begin
				slot_addr[i] <= '0;
				slot_ctrl[i] <= '0;
			end
		end else begin
			type_sel <= next_type_sel;
			line_en <= next_line_en;
			soft_req <= next_soft_req;
			def_addr <= next_def_addr;
			evt_en <= next_evt_en;
			for (int i = 0; i < VIP_SLOTS; i++) begin
				slot_addr[i] <= next_slot_addr[i];
				slot_ctrl[i] <= next_slot_ctrl[i];
			end
		end
	end

	// Service tracking: read acknowledges, write ends
	always_comb begin
		next_in_service = in_service;
		// Acknowledge marks the winner's level
		if (bus.rd && is_cur && irq_req)
			next_in_service[win_lvl] = 1'b1;
		// End of service frees the highest active level
		if (bus.wr && is_cur) begin
			for (int i = 0; i < VIP_SVC_W; i++) begin
				if (5'(i) == act_lvl)
					next_in_service[i] = 1'b0;
			end
		end
	end

	// Service stack register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			in_service <= '0;
		else
			in_service <= next_in_service;
	end

	// Read data, valid the cycle after the strobe
	always_comb begin
		next_rdata = '0;
		if (bus.rd) begin
			case (bus.addr)
				VIP_IRQ_STATUS: next_rdata = irq_stat;
				VIP_FIQ_STATUS: next_rdata = fiq_stat;
				VIP_RAW_STATUS: next_rdata = raw_lines;
				VIP_TYPE_SELECT: next_rdata = type_sel;
				VIP_LINE_ENABLE: next_rdata = line_en;
				VIP_SOFT_RAISE: next_rdata = soft_req;
				VIP_DEFAULT_VECTOR: next_rdata = def_addr;
				VIP_EVENT_STATUS: next_rdata = 32'(evt_stat);
				VIP_EVENT_ENABLE: next_rdata = 32'(evt_en);
				VIP_CURRENT_VECTOR: begin
					if (irq_req && win_lvl < VIP_LVL_DEF)
						next_rdata = slot_addr[win_lvl[3:0]];
					else
						next_rdata = def_addr;
				end
				default: begin
					if (is_slot_a)
						next_rdata = slot_addr[slot_idx];
					if (is_slot_c)
						next_rdata = 32'({slot_ctrl[slot_idx].en,
							slot_ctrl[slot_idx].src});
				end
			endcase
		end
	end

	// Sticky events, set beats clear
	always_comb begin
		next_evt_stat = evt_stat;
		if (bus.wr && bus.addr == VIP_EVENT_CLEAR)
			next_evt_stat = evt_stat & ~bus.wdata[VIP_EVT_W-1:0];
		if (bus.rd && is_cur && irq_req)
			next_evt_stat[VIP_EVT_START] = 1'b1;
		if (bus.wr && is_cur && |in_service)
			next_evt_stat[VIP_EVT_END] = 1'b1;
		if ((bus.wr || bus.rd) && !mapped)
			next_evt_stat[VIP_EVT_BAD] = 1'b1;
		next_event_irq = |(next_evt_stat & evt_en);
	end

	// Core request outputs
	always_comb begin
		next_irq_out = irq_req;
		next_fiq_out = |fiq_stat;
	end

	// Read data register, zero outside the read slot
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			rdata <= '0;
		else
			rdata <= next_rdata;
	end

	// Event status and its interrupt
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			evt_stat <= '0;
			event_irq <= 1'b0;
		end else begin
			evt_stat <= next_evt_stat;
			event_irq <= next_event_irq;
		end
	end

	// Core request lines
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_out <= 1'b0;
			fiq_out <= 1'b0;
		end else begin
			irq_out <= next_irq_out;
			fiq_out <= next_fiq_out;
		end
	end

endmodule // vip_controller

// *** vip_controller_properties.sv ***
module vip_controller_properties
	import vip_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire vip_bus_t bus,
	input wire logic [31:0] rdata,
	input wire logic [31:0] periph_irq,
	input wire logic [VIP_EXT-1:0] ext_irq_pin,
	input wire logic irq_out,
	input wire logic fiq_out,
	input wire logic event_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] hist;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Recent pin activity or writes that may raise an output
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hist <= '0;
		end else begin
			hist <= {hist[6:0], (|ext_irq_pin) | bus.wr};
		end
	end
	a_reset_quiet: assert property (
		$rose(rst_n) |-> !irq_out && !fiq_out && !event_irq)
		else $error("output high at reset release");
	a_rdata_idle: assert property (
		!$past(bus.rd) |-> rdata == '0)
		else $error("read data outside read slot");
	a_hole_zero: assert property (
		$past(bus.rd) && $past(bus.addr) == 12'h020 |-> rdata == '0)
		else $error("unmapped read not zero");
	a_wo_zero: assert property (
		$past(bus.rd) && $past(bus.addr) == VIP_LINE_DISABLE
		|-> rdata == '0)
		else $error("disable read not zero");
	a_clr_zero: assert property (
		$past(bus.rd) && $past(bus.addr) == VIP_EVENT_CLEAR
		|-> rdata == '0)
		else $error("event clear read not zero");
	a_irq_cause: assert property (
		$rose(irq_out) |-> $past(periph_irq) != '0 || hist != '0)
		else $error("irq raised without cause");
	a_fiq_cause: assert property (
		$rose(fiq_out) |-> $past(periph_irq) != '0 || hist != '0)
		else $error("fiq raised without cause");
	a_core_steady: assert property (
		(!bus.wr && !bus.rd && $stable(periph_irq)
		&& $stable(ext_irq_pin)) [*6] |=> $stable(irq_out)
		&& $stable(fiq_out))
		else $error("core output moved while quiet");
	a_event_steady: assert property (
		(!bus.wr && !bus.rd) [*3] |=> $stable(event_irq))
		else $error("event output moved while quiet");
endmodule // vip_controller_properties

bind vip_controller vip_controller_properties u_vip_controller_properties (
	.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .rdata(rdata),
	.periph_irq(periph_irq), .ext_irq_pin(ext_irq_pin),
	.irq_out(irq_out), .fiq_out(fiq_out), .event_irq(event_irq));

// *** vip_controller_tb.sv ***
module vip_controller_tb
	import vip_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	vip_bus_t bus = '0;
	logic [31:0] req = '0;
	logic [31:0] rdata, periph_irq, d;
	logic [7:0] ext_irq_pin;
	logic irq_out, fiq_out, event_irq;
	int err_count = 0;
	int tests_run = 0;
	always #2.5 clk_sys = ~clk_sys;
	vip_src_model u_vip_src_model (.clk_sys(clk_sys), .rst_n(rst_n),
		.req(req), .periph_irq(periph_irq), .ext_irq_pin(ext_irq_pin));
	vip_controller u_vip_controller (.clk_sys(clk_sys), .rst_n(rst_n),
		.bus(bus), .rdata(rdata), .periph_irq(periph_irq),
		.ext_irq_pin(ext_irq_pin), .irq_out(irq_out),
		.fiq_out(fiq_out), .event_irq(event_irq));
	// Bus cycles, each followed by an idle cycle
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge clk_sys);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
			err_count++;
		end
	endtask
	task automatic ck(input string n, input logic [31:0] e,
		input logic [11:0] a);
		rd(a);
		chk(n, e, d);
	endtask
	task automatic conclude();
		$display("errors %0d checks %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Hang guard
	initial begin
		#50000;
		err_count++;
		conclude();
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		ck("type", '0, VIP_TYPE_SELECT);
		ck("enable", '0, VIP_LINE_ENABLE);
		for (int i = 0; i < VIP_SLOTS; i++) begin
			ck("slot", '0, {VIP_SLOT_CTRL_PAGE, 8'(4 * i)});
		end
		// Default-vectored watchdog line
		wr(VIP_DEFAULT_VECTOR, 32'h0000_0D00);
		req <= 32'h1;
		settle(4);
		chk("irq off", '0, irq_out);
		wr(VIP_LINE_ENABLE, 32'h1);
		settle(3);
		chk("irq on", 1, irq_out);
		ck("raw", 32'h1, VIP_RAW_STATUS);
		ck("ack def", 32'h0000_0D00, VIP_CURRENT_VECTOR);
		settle(1);
		chk("masked", '0, irq_out);
		wr(VIP_CURRENT_VECTOR, '0);
		settle(3);
		chk("reissue", 1, irq_out);
		ck("ack2", 32'h0000_0D00, VIP_CURRENT_VECTOR);
		req <= '0;
		wr(VIP_CURRENT_VECTOR, '0);
		wr(VIP_LINE_DISABLE, 32'h1);
		ck("en off", '0, VIP_LINE_ENABLE);
		// Slot 3 takes the clock line, slot 9 line 4, line 5 default
		wr({VIP_SLOT_ADDR_PAGE, 8'h0C}, 32'h0000_3300);
		wr({VIP_SLOT_CTRL_PAGE, 8'h0C}, 32'h0000_002F);
		wr({VIP_SLOT_ADDR_PAGE, 8'h24}, 32'h0000_9900);
		wr({VIP_SLOT_CTRL_PAGE, 8'h24}, 32'h0000_0024);
		wr(VIP_LINE_ENABLE, 32'h0000_8030);
		req <= 32'h0000_0030;
		settle(3);
		ck("slot9", 32'h0000_9900, VIP_CURRENT_VECTOR);
		settle(1);
		chk("low masked", '0, irq_out);
		req <= 32'h0000_8030;
		settle(3);
		chk("high passes", 1, irq_out);
		ck("slot3", 32'h0000_3300, VIP_CURRENT_VECTOR);
		req <= 32'h0000_0020;
		wr(VIP_CURRENT_VECTOR, '0);
		settle(3);
		chk("nested", '0, irq_out);
		wr(VIP_CURRENT_VECTOR, '0);
		settle(3);
		chk("next", 1, irq_out);
		ck("def", 32'h0000_0D00, VIP_CURRENT_VECTOR);
		req <= '0;
		wr(VIP_CURRENT_VECTOR, '0);
		// Fast line 2, external pin 0 and the spare line
		wr(VIP_TYPE_SELECT, 32'h4);
		wr(VIP_LINE_ENABLE, 32'h0000_0086);
		req <= 32'h0000_0084;
		settle(8);
		chk("fiq", 1, fiq_out);
		ck("fiq st", 32'h4, VIP_FIQ_STATUS);
		ck("ext", 32'h0000_0080, VIP_IRQ_STATUS);
		wr(VIP_SOFT_RAISE, 32'h2);
		ck("spare", 32'h0000_0082, VIP_IRQ_STATUS);
		wr(VIP_SOFT_CLEAR, 32'h2);
		ck("spare clr", 32'h0000_0080, VIP_IRQ_STATUS);
		// Unmapped access raises the event output
		ck("hole", '0, 12'h020);
		ck("wo", '0, VIP_LINE_DISABLE);
		ck("wo2", '0, VIP_EVENT_CLEAR);
		wr(VIP_EVENT_ENABLE, 32'h4);
		settle(3);
		chk("event", 1, event_irq);
		wr(VIP_EVENT_CLEAR, 32'h4);
		settle(3);
		chk("event clr", '0, event_irq);
		ck("evt st", 32'h3, VIP_EVENT_STATUS);
		conclude();
	end
endmodule // vip_controller_tb

// *** vip_pkg.sv ***
package vip_pkg;
	localparam int VIP_LINES = 32;
	localparam int VIP_SLOTS = 16;
	localparam int VIP_EXT = 8;
	localparam int VIP_AW = 12;
	// Fixed line positions
	localparam int VIP_LINE_WATCHDOG = 0;
	localparam int VIP_LINE_SPARE = 1;
	localparam int VIP_LINE_COMM_RX = 2;
	localparam int VIP_LINE_COMM_TX = 3;
	localparam int VIP_LINE_EXT0 = 7;
	localparam int VIP_LINE_RTC = 15;
	// Register offsets
	localparam logic [11:0] VIP_IRQ_STATUS = 12'h000;
	localparam logic [11:0] VIP_FIQ_STATUS = 12'h004;
	localparam logic [11:0] VIP_RAW_STATUS = 12'h008;
	localparam logic [11:0] VIP_TYPE_SELECT = 12'h00C;
	localparam logic [11:0] VIP_LINE_ENABLE = 12'h010;
	localparam logic [11:0] VIP_LINE_DISABLE = 12'h014;
	localparam logic [11:0] VIP_SOFT_RAISE = 12'h018;
	localparam logic [11:0] VIP_SOFT_CLEAR = 12'h01C;
	localparam logic [11:0] VIP_CURRENT_VECTOR = 12'h030;
	localparam logic [11:0] VIP_DEFAULT_VECTOR = 12'h034;
	localparam logic [11:0] VIP_EVENT_STATUS = 12'h040;
	localparam logic [11:0] VIP_EVENT_CLEAR = 12'h044;
	localparam logic [11:0] VIP_EVENT_ENABLE = 12'h048;
	localparam logic [3:0] VIP_SLOT_ADDR_PAGE = 4'h1;
	localparam logic [3:0] VIP_SLOT_CTRL_PAGE = 4'h2;
	// Slot control fields
	localparam int VIP_CTRL_EN_BIT = 5;
	localparam int VIP_SRC_W = 5;
	// Slot page address fields
	localparam int VIP_IDX_LSB = 2;
	localparam int VIP_IDX_MSB = 5;
	localparam int VIP_GAP_LSB = 6;
	localparam int VIP_GAP_MSB = 7;
	localparam int VIP_PAGE_LSB = 8;
	localparam int VIP_PAGE_MSB = 11;
	// Priority levels: 0..15 vectored, 16 default, 17 idle
	localparam logic [4:0] VIP_LVL_DEF = 5'h10;
	localparam logic [4:0] VIP_LVL_NONE = 5'h11;
	localparam int VIP_SVC_W = 17;
	// Event status bits
	localparam int VIP_EVT_START = 0;
	localparam int VIP_EVT_END = 1;
	localparam int VIP_EVT_BAD = 2;
	localparam int VIP_EVT_W = 3;

	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} vip_bus_t;

	typedef struct packed {
		logic en;
		logic [4:0] src;
	} vip_slot_ctrl_t;
endpackage

// *** vip_src_model.sv ***
module vip_src_model (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [31:0] req,
	output logic [31:0] periph_irq,
	output logic [7:0] ext_irq_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// Sources hold a level until cleared at the source
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			periph_irq <= '0;
			ext_irq_pin <= '0;
		end else begin
			periph_irq <= req & ~32'h0000_7F82;
			ext_irq_pin <= req[14:7];
		end
	end
endmodule // vip_src_model
